// ==== ebabe_bus.v ====
// External bus address output, address latch strobe and byte enables.
// Assumes cycle requests are synchronous to clk and held until done.
// Port values for the shared pins arrive ready-made from outside.
//
// Contract
// - Hold address bits 0-15 whole cycle
// - Hold address bits 16-19 whole cycle
// - Only low 20 of 24 bits leave
// - Fetch starts at FF2080H after reset
// - Multiplexed: address on shared lines first
// - Data phase carries 8 or 16 bits
// - Latch strobe only on external cycles
// - Latch strobe marks cycle start, valid address
// - Upper enable low for word/high-byte access on a 16-bit bus; held high on an 8-bit bus
// - Lanes decoded from access width and bit 0
// - Config bit 2 picks enable or write strobe
// - Upper address shares pins with extended port
`timescale 1ns/1ps
`include "ebabe_regs.vh"
module ebabe_bus #(
   parameter CFG_W = 8
) (
   // Clock and reset
   input  wire                          clk,
   input  wire                          reset_n,
   // Core request
   input  wire                          req,
   input  wire [`EBABE_INT_ADDR_W-1:0]  req_addr,
   input  wire                          req_write,
   input  wire                          req_word,
   input  wire                          req_bus16,
   input  wire                          req_muxed,
   input  wire                          req_external,
   input  wire [`EBABE_DATA_W-1:0]      req_wdata,
   input  wire [CFG_W-1:0]              chip_config_reg_zero,
   // Port functions of the shared pins
   input  wire [`EBABE_UP_ADDR_W-1:0]   extended_port_out,
   input  wire [`EBABE_LOW_ADDR_W-1:0]  gp_port_out,
   // Core answer
   output reg                           done,
   output reg  [`EBABE_DATA_W-1:0]      rdata,
   output reg  [`EBABE_INT_ADDR_W-1:0]  fetch_addr,
   // External pins
   output reg  [`EBABE_LOW_ADDR_W-1:0]  sys_addr_low,
   output reg  [`EBABE_UP_ADDR_W-1:0]   addr_upper_nibble,
   input  wire [`EBABE_DATA_W-1:0]      muxed_addr_data_lines_in,
   output reg  [`EBABE_DATA_W-1:0]      muxed_addr_data_lines_out,
   output reg  [`EBABE_DATA_W-1:0]      muxed_addr_data_lines_oe,
   output reg                           ale,
   output reg                           upper_byte_enable_n,
   output reg                           high_byte_write_strobe_n,
   output reg                           byte_pin_n
);
   // ******************************
   // Cycle sequencer
   // ******************************
   // Fixed four-clock external cycle with no wait states: slow memory
   // must answer within the single data clock.
   localparam ST_IDLE = 2'b00;
   localparam ST_ADDR = 2'b01;
   localparam ST_DATA = 2'b10;
   localparam ST_END  = 2'b11;
   // Zero bits added when the external address returns to the core
   localparam PAD_W   = `EBABE_INT_ADDR_W - `EBABE_EXT_ADDR_W;

   reg  [1:0]                    state_reg;
   reg  [1:0]                    state_next;
   // Attributes are sampled once, at the take edge
   reg  [`EBABE_EXT_ADDR_W-1:0]  addr_reg;
   reg                           write_reg;
   reg                           lane_lo_reg;
   reg                           lane_hi_reg;
   reg  [`EBABE_DATA_W-1:0]      wdata_reg;
   wire                          lane_lo;
   wire                          lane_hi;
   wire                          sel_byte_en;

   // Lanes decoded straight from the request, ready at the take edge
   ebabe_lane_dec u_dec (
      .bus16     (req_bus16),
      .word      (req_word),
      .a0        (req_addr[0]),
      .lane_low  (lane_lo),
      .lane_high (lane_hi)
   );

   // Software may change the pin function between cycles
   assign sel_byte_en = chip_config_reg_zero[`EBABE_CFG_BYTE_EN];

   // ******************************
   // Lane decoding
   // ******************************
   // One enable bit per data line. The same mask drives the write lanes
   // and gates the read data, so both agree on which bytes are live.
   function [`EBABE_DATA_W-1:0] lane_mask;
      input lo;
      input hi;
      begin
         lane_mask = {{`EBABE_BYTE_W{hi}}, {`EBABE_BYTE_W{lo}}};
      end
   endfunction

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            // Requests arriving mid-cycle wait until idle
            if (req && req_external) begin
               state_next = ST_ADDR;
            end
         end
         ST_ADDR: state_next = ST_DATA;
         ST_DATA: state_next = ST_END;
         ST_END:  state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // ******************************
   // Registers and pins
   // ******************************
   always @(posedge clk) begin
      if (!reset_n) begin
         state_reg                 <= ST_IDLE;
         addr_reg                  <= {`EBABE_EXT_ADDR_W{1'b0}};
         write_reg                 <= 1'b0;
         lane_lo_reg               <= 1'b0;
         lane_hi_reg               <= 1'b0;
         wdata_reg                 <= {`EBABE_DATA_W{1'b0}};
         done                      <= 1'b0;
         rdata                     <= {`EBABE_DATA_W{1'b0}};
         fetch_addr                <= `EBABE_RESET_FETCH;
         sys_addr_low              <= {`EBABE_LOW_ADDR_W{1'b0}};
         addr_upper_nibble         <= {`EBABE_UP_ADDR_W{1'b0}};
         muxed_addr_data_lines_out <= {`EBABE_DATA_W{1'b0}};
         muxed_addr_data_lines_oe  <= {`EBABE_DATA_W{1'b0}};
         ale                       <= 1'b0;
         upper_byte_enable_n       <= 1'b1;
         high_byte_write_strobe_n  <= 1'b1;
      end else begin
         state_reg <= state_next;
         // Strobes default low, so each lasts exactly one clock
         done      <= 1'b0;
         ale       <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               high_byte_write_strobe_n <= 1'b1;
               if (req && !req_external) begin
                  // Internal access: no strobe, pins stay as ports
                  done <= 1'b1;
               end
               if (req && req_external) begin
                  // Drop bits 23..20; external space is one megabyte
                  addr_reg <= req_addr[`EBABE_EXT_ADDR_W-1:0];
                  write_reg   <= req_write;
                  lane_lo_reg <= lane_lo;
                  lane_hi_reg <= lane_hi;
                  wdata_reg   <= req_wdata;
                  sys_addr_low <=
                     req_addr[`EBABE_LOW_ADDR_W-1:0];
                  addr_upper_nibble <=
                     req_addr[`EBABE_EXT_ADDR_W-1:`EBABE_LOW_ADDR_W];
                  ale <= 1'b1;
                  if (req_muxed) begin
                     muxed_addr_data_lines_out <=
                        req_addr[`EBABE_LOW_ADDR_W-1:0];
                     muxed_addr_data_lines_oe <= {`EBABE_DATA_W{1'b1}};
                  end else begin
                     muxed_addr_data_lines_oe <= {`EBABE_DATA_W{1'b0}};
                  end
                  // Enable low for word or high-byte lanes
                  upper_byte_enable_n <= ~lane_hi;
               end else begin
                  // Shared pins fall back to port functions
                  addr_upper_nibble <= extended_port_out;
                  muxed_addr_data_lines_out <= gp_port_out;
                  upper_byte_enable_n <= 1'b1;
               end
            end
            ST_ADDR: begin
               // Data phase: drive lanes on write, release on read
               muxed_addr_data_lines_out <= wdata_reg;
               muxed_addr_data_lines_oe <= write_reg ?
                  lane_mask(lane_lo_reg, lane_hi_reg) :
                  {`EBABE_DATA_W{1'b0}};
               high_byte_write_strobe_n <= ~(write_reg && lane_hi_reg);
            end
            ST_DATA: begin
               // Sample the far side at the end of the data clock
               // Lanes not in use read back as zero
               rdata <= muxed_addr_data_lines_in &
                  lane_mask(lane_lo_reg, lane_hi_reg);
            end
            ST_END: begin
               // Release the lines before the next address phase
               high_byte_write_strobe_n <= 1'b1;
               muxed_addr_data_lines_oe <= {`EBABE_DATA_W{1'b0}};
               done       <= 1'b1;
               // Report the external address back to the core
               fetch_addr <= {{PAD_W{1'b0}}, addr_reg};
            end
            default: ;
         endcase
      end
   end

   // ******************************
   // Shared byte pin
   // ******************************
   // The pin follows its source one clock late, so a board that samples
   // it with the address strobe sees the previous cycle's value.
   always @(posedge clk) begin
      if (!reset_n) begin
         byte_pin_n <= 1'b1;
      end else if (sel_byte_en) begin
         byte_pin_n <= upper_byte_enable_n;
      end else begin
         byte_pin_n <= high_byte_write_strobe_n;
      end
   end
endmodule

// ==== ebabe_regs.vh ====
// Constants for the external bus address and byte-enable block.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef EBABE_REGS_VH
`define EBABE_REGS_VH
`define EBABE_INT_ADDR_W     24
`define EBABE_EXT_ADDR_W     20
`define EBABE_LOW_ADDR_W     16
`define EBABE_UP_ADDR_W      4
`define EBABE_RESET_FETCH    24'hFF2080
`define EBABE_EXT_MASK       24'h0FFFFF
`define EBABE_CFG_BYTE_EN    2
`define EBABE_CFG_RESET      8'h04
`define EBABE_DATA_W         16
`define EBABE_BYTE_W         8
`endif

// ==== ebabe_lane_dec.v ====
// Byte-lane decoder: access width and address bit 0 to lane enables.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
module ebabe_lane_dec (
   // Access description
   input  wire       bus16,
   input  wire       word,
   input  wire       a0,
   // Lane enables, active high
   output reg        lane_low,
   output reg        lane_high
);
   always @* begin
      if (!bus16) begin
         lane_low  = 1'b1;
         lane_high = 1'b0;
      end else if (word) begin
         lane_low  = 1'b1;
         lane_high = 1'b1;
      end else begin
         lane_low  = ~a0;
         lane_high = a0;
      end
   end
endmodule

// ==== ebabe_bus_properties.sv ====
// Checker for the external bus address and byte-enable block.
// Assumes it is bound to ebabe_bus and sees only its ports.
`timescale 1ns/1ps
module ebabe_bus_props #(parameter CFG_W = 8) (
   input wire clk, reset_n, req, req_write, req_word, req_bus16,
   input wire req_muxed, req_external, done, ale, upper_byte_enable_n,
   input wire high_byte_write_strobe_n, byte_pin_n,
   input wire [23:0] req_addr, fetch_addr,
   input wire [15:0] req_wdata, gp_port_out, rdata, sys_addr_low,
   input wire [15:0] muxed_addr_data_lines_in, muxed_addr_data_lines_out,
   input wire [15:0] muxed_addr_data_lines_oe,
   input wire [3:0] extended_port_out, addr_upper_nibble,
   input wire [CFG_W-1:0] chip_config_reg_zero
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_ext; ale |-> req && req_external; endproperty
   a_ext: assert property (p_ext) else $error("strobe on internal");
   property p_adr;
      ale |-> {addr_upper_nibble, sys_addr_low} == req_addr[19:0];
   endproperty
   a_adr: assert property (p_adr) else $error("bad address");
   property p_hold;
      ale |=> $stable({addr_upper_nibble, sys_addr_low})[*3];
   endproperty
   a_hold: assert property (p_hold) else $error("address moved");
   property p_mux;
      ale && req_muxed |-> muxed_addr_data_lines_out == sys_addr_low
         && &muxed_addr_data_lines_oe;
   endproperty
   a_mux: assert property (p_mux) else $error("no muxed address");
   property p_len; ale |-> !done[*3] ##1 done; endproperty
   a_len: assert property (p_len) else $error("cycle length");
   property p_ube;
      ale && chip_config_reg_zero[2] |-> upper_byte_enable_n ==
         !(req_bus16 && (req_word || req_addr[0]));
   endproperty
   a_ube: assert property (p_ube) else $error("bad enable");
   property p_pin;
      byte_pin_n == ($past(chip_config_reg_zero[2]) ?
         $past(upper_byte_enable_n) : $past(high_byte_write_strobe_n));
   endproperty
   a_pin: assert property (p_pin) else $error("bad pin");
   property p_fetch; $rose(reset_n) |-> fetch_addr == 24'hFF2080; endproperty
   a_fetch: assert property (p_fetch) else $error("bad fetch");
   property p_wdat;
      ale && req_write |=> muxed_addr_data_lines_out == req_wdata
         && muxed_addr_data_lines_oe[15:8] ==
            {8{req_bus16 && (req_word || req_addr[0])}}
         && muxed_addr_data_lines_oe[7:0] ==
            {8{!req_bus16 || req_word || !req_addr[0]}};
   endproperty
   a_wdat: assert property (p_wdat) else $error("bad write lanes");
   property p_rdoe;
      ale && !req_write |=> muxed_addr_data_lines_oe == 16'h0000;
   endproperty
   a_rdoe: assert property (p_rdoe) else $error("read not released");
   property p_wrh;
      ale |=> high_byte_write_strobe_n ==
         !(req_write && req_bus16 && (req_word || req_addr[0]));
   endproperty
   a_wrh: assert property (p_wrh) else $error("bad write strobe");
   c_mux: cover property (ale && req_muxed);
   c_word: cover property (ale && req_word && req_bus16);
   c_int: cover property (done && !req_external);
   c_wr: cover property (ale && req_write);
endmodule
bind ebabe_bus ebabe_bus_props #(.CFG_W(CFG_W)) u_props (.*);

// ==== ebabe_mem_model.sv ====
// External memory with address latch on the far side of the bus.
// Assumes it shares clk with the bus; writes are not stored.
`timescale 1ns/1ps
module ebabe_mem_model (
   input wire        clk, ale, done,
   input wire [3:0]  addr_upper_nibble,
   input wire [15:0] sys_addr_low, muxed_addr_data_lines_out,
   input wire [15:0] muxed_addr_data_lines_oe,
   output wire [15:0] mem_d
);
   reg [15:0] lat_reg = 16'h0000, tog_reg = 16'h0000;
   reg        act_reg = 1'b0;
   always @(posedge clk) begin
      if (ale) begin
         lat_reg <= &muxed_addr_data_lines_oe ?
            muxed_addr_data_lines_out : sys_addr_low;
      end
      act_reg <= ale | (act_reg & ~done);
      tog_reg <= ~tog_reg;
   end
   // Released lines toggle so a stale value can never match
   assign mem_d = (act_reg && muxed_addr_data_lines_oe == 16'h0000) ?
      lat_reg ^ 16'h5A3C : tog_reg;
endmodule

// ==== tb.sv ====
// Self-checking bench for ebabe_bus with a memory model.
// Assumes all files sit in one folder.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
   reg clk = 0, reset_n = 0, req = 0, req_write = 0, req_word = 0;
   reg req_bus16 = 0, req_muxed = 0, req_external = 0;
   reg [23:0] req_addr = 0;
   reg [15:0] req_wdata = 0, gp_port_out = 0, f;
   reg [7:0] chip_config_reg_zero = 8'h04;
   reg [3:0] extended_port_out = 0;
   wire done, ale, upper_byte_enable_n, high_byte_write_strobe_n, byte_pin_n;
   wire [23:0] fetch_addr;
   wire [15:0] rdata, sys_addr_low, mem_d, muxed_addr_data_lines_in;
   wire [15:0] muxed_addr_data_lines_out, muxed_addr_data_lines_oe;
   wire [3:0] addr_upper_nibble;
   logic [16:0] expq[$];
   logic [16:0] m;
   int mismatches = 0, cmp_count = 0, i;
   assign muxed_addr_data_lines_in = (muxed_addr_data_lines_oe &
      muxed_addr_data_lines_out) | (~muxed_addr_data_lines_oe & mem_d);
   always #10 clk = ~clk;
   ebabe_bus i_dut (.*);
   ebabe_mem_model i_mem (.*);
   task rst;
      reset_n = 0;
      {extended_port_out, gp_port_out} = 20'($urandom);
      repeat (8) @(negedge clk);
      reset_n = 1;
      repeat (2) @(negedge clk);
      `CHK(fetch_addr, 24'hFF2080)
      `CHK(addr_upper_nibble, extended_port_out)
      `CHK(muxed_addr_data_lines_out, gp_port_out)
      $display("reset test done");
   endtask
   // Leaves req high so the next call makes a back-to-back request
   task acc;
      {req_external, req_muxed, req_bus16, req_word, req_write} =
         5'($urandom);
      req_addr = 24'($urandom);
      req_wdata = 16'($urandom);
      chip_config_reg_zero[2] = 1'($urandom);
      f = req_addr[15:0] ^ 16'h5A3C;
      expq.push_back({req_external && !req_write,
         req_bus16 && (req_word || req_addr[0]) ? f[15:8] : 8'h00,
         !req_bus16 || req_word || !req_addr[0] ? f[7:0] : 8'h00});
      req = 1;
      i = 0;
      do begin @(negedge clk); i++; end while (done !== 1'b1 && i < 8);
      `CHK(done, 1'b1)
   endtask
   always @(negedge clk) if (done === 1'b1 && expq.size() > 0) begin
      m = expq.pop_front();
      if (m[16]) `CHK(rdata, m[15:0])
   end
   task results;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      i = $urandom(51);
      rst;
      repeat (40) acc;
      req = 0;
      $display("traffic test done");
      rst;
      repeat (40) acc;
      req = 0;
      $display("second traffic test done");
      results;
   end
   initial begin
      #100000;
      mismatches++;
      results;
   end
endmodule
